// File: rtl/assc_defines.vh
`ifndef ASSC_DEFINES_VH
`define ASSC_DEFINES_VH
// Register indices; byte address is four times the index.
`define ASSC_IDX_STATUS   3'h0
`define ASSC_IDX_CTRL1    3'h1
`define ASSC_IDX_CTRL2    3'h2
`define ASSC_IDX_DATA     3'h3
`define ASSC_IDX_BAUD     3'h4
// Status register bit positions.
`define ASSC_ST_PARITY_ERROR_FLAG      7
`define ASSC_ST_NF        6
`define ASSC_ST_FRAMING_ERROR_FLAG      5
`define ASSC_ST_OVERRUN_FLAG      4
`define ASSC_ST_RECEIVER_IDLE_FLAG     3
`define ASSC_ST_RECEIVE_AVAILABLE_FLAG      2
`define ASSC_ST_TRANSMIT_IDLE_FLAG     1
`define ASSC_ST_TRANSMIT_EMPTY_FLAG      0
`define ASSC_STATUS_RST   8'h0b
// Control one bit positions.
`define ASSC_C1_UEN       7
`define ASSC_C1_NINE      6
`define ASSC_C1_PARITY_ENABLE      5
`define ASSC_C1_PODD      4
`define ASSC_C1_STOP2     3
`define ASSC_C1_BRK       2
`define ASSC_C1_RX8       1
`define ASSC_C1_TX8       0
// Control two bit positions.
`define ASSC_C2_TRANSMITTER_ENABLE      7
`define ASSC_C2_RECEIVER_ENABLE      6
`define ASSC_C2_BRGH      5
`define ASSC_C2_RIE       2
`define ASSC_CTRL_RST     8'h00
// Bit timing: oversample ticks, low-speed divide count and bit counts.
`define ASSC_OVS_LAST     4'hf
`define ASSC_SMP_A        4'h7
`define ASSC_SMP_B        4'h8
`define ASSC_SMP_C        4'h9
`define ASSC_LOW_DIV_LAST 2'h3
`define ASSC_BRK_BITS     4'hd
`define ASSC_BITS8_LAST   4'h7
`define ASSC_BITS9_LAST   4'h8
`endif

// File: rtl/assc_top.v
// Notes on behaviour
// - Parity error set on bad parity, read-then-access clears
// - Noise set with receive flag, not on overrun
// - Framing error set on bad stop, read-then-access clears
// - Overrun sets flag and blocks transfers until cleared
// - Receiver idle low from start to stop end
// - Word transfer sets available flag and errors together
// - Available flag clears after status, data read, empty
// - Transmit idle when empty, nothing sent, line high
// - Transmit idle clears on status read then write; the code clears it on any data write
// - Transmit empty set on shift load, cleared by write
// - Enabling transmitter also sets transmit empty
// - Port disable floats pins, else direction enables rule
// - Disable flushes, resets flags, keeps other configuration
// - Disable aborts activity, re-enable keeps configuration
// - Eight or nine data bits, ninth bits held
// - Parity generated and checked only when enabled
// - Parity select: zero even, one odd
// - One or two stop bits per frame
// - Break holds line low thirteen bits minimum
// - Received ninth bit read-only, transmit ninth write-only
// - Bits shifted least significant first at baud rate
// - Interrupt request from enable with overrun or available
// - Baud divisor is unsigned eight-bit divide factor
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "assc_defines.vh"
module assc_top (
  input  wire       clock_i,
  input  wire       rst_i,
  input  wire [2:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       rx_i,
  output reg        tx_o,
  output reg        tx_oe_n_o,
  output reg        rx_en_o,
  output reg        irq_o
);
  localparam [5:0] T_IDLE = 6'h01, T_START = 6'h02, T_DATA = 6'h04,
                   T_PAR = 6'h08, T_STOP = 6'h10, T_BRK = 6'h20;
  localparam [4:0] R_IDLE = 5'h01, R_START = 5'h02, R_DATA = 5'h04,
                   R_PAR = 5'h08, R_STOP = 5'h10;

  function maj3;
    input [2:0] s;
    begin
      maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
    end
  endfunction

  function is_reg;
    input [2:0] a;
    input [2:0] idx;
    begin
      is_reg = (a == idx);
    end
  endfunction

  reg  [7:0]  c1_ff;
  reg  [7:0]  c2_ff;
  reg  [7:0]  baud_ff;
  reg  [7:0]  presc_ff;
  reg  [1:0]  quart_ff;
  reg         samp_ff;
  reg  [2:0]  rx_sync_ff;
  reg         rx_filt_ff;
  reg         armed_ff;
  reg         parity_error_flag_ff;
  reg         nf_ff;
  reg         framing_error_flag_ff;
  reg         overrun_flag_ff;
  reg         transmit_empty_flag_ff;
  reg  [11:0] rxq_ff [0:1];
  reg  [1:0]  rx_cnt_ff;
  reg  [5:0]  tst_ff;
  reg  [3:0]  t_ovs_ff;
  reg  [3:0]  t_bit_ff;
  reg  [8:0]  t_sh_ff;
  reg  [8:0]  t_buf_ff;
  reg         t_full_ff;
  reg         t_par_ff;
  reg  [4:0]  rst_ff;
  reg  [3:0]  r_ovs_ff;
  reg  [3:0]  r_bit_ff;
  reg  [8:0]  r_sh_ff;
  reg  [2:0]  r_smp_ff;
  reg         r_nf_ff;
  reg         r_par_ff;
  reg         transmitter_enable_d_ff;

  wire uen    = c1_ff[`ASSC_C1_UEN];
  wire nine   = c1_ff[`ASSC_C1_NINE];
  wire parity_enable   = c1_ff[`ASSC_C1_PARITY_ENABLE];
  wire podd   = c1_ff[`ASSC_C1_PODD];
  wire stop2  = c1_ff[`ASSC_C1_STOP2];
  wire brk    = c1_ff[`ASSC_C1_BRK];
  wire tx_on  = uen & c2_ff[`ASSC_C2_TRANSMITTER_ENABLE];
  wire rx_on  = uen & c2_ff[`ASSC_C2_RECEIVER_ENABLE];
  wire [3:0] bits_last = nine ? `ASSC_BITS9_LAST : `ASSC_BITS8_LAST;

  wire acc_st  = is_reg(addr_i, `ASSC_IDX_STATUS);
  wire acc_dat = is_reg(addr_i, `ASSC_IDX_DATA);
  wire st_rd   = rd_i & acc_st;
  wire dat_rd  = rd_i & acc_dat;
  wire dat_wr  = wr_i & acc_dat;
  wire dat_acc = (dat_rd | dat_wr) & armed_ff;

  wire receive_available_flag   = (rx_cnt_ff != 2'h0);
  wire receiver_idle_flag  = rst_ff[0];
  wire transmit_idle_flag  = transmit_empty_flag_ff & ~t_full_ff & tst_ff[0] & ~brk;
  wire [7:0] status = {parity_error_flag_ff, nf_ff, framing_error_flag_ff, overrun_flag_ff, receiver_idle_flag, receive_available_flag, transmit_idle_flag, transmit_empty_flag_ff};

  // Baud timer: N+1 clocks per oversample tick, times four in low speed.
  always @(posedge clock_i) begin
    if (rst_i || !uen) begin
      presc_ff <= 8'h00;
      quart_ff <= 2'h0;
      samp_ff  <= 1'b0;
    end else begin
      samp_ff <= 1'b0;
      if (presc_ff == baud_ff) begin
        presc_ff <= 8'h00;
        quart_ff <= quart_ff + 2'h1;
        samp_ff  <= c2_ff[`ASSC_C2_BRGH] | (quart_ff == `ASSC_LOW_DIV_LAST);
      end else begin
        presc_ff <= presc_ff + 8'h01;
      end
    end
  end

  // Configuration registers.
  always @(posedge clock_i) begin
    if (rst_i) begin
      c1_ff   <= `ASSC_CTRL_RST;
      c2_ff   <= `ASSC_CTRL_RST;
      baud_ff <= 8'h00;
    end else begin
      if (wr_i && is_reg(addr_i, `ASSC_IDX_CTRL1))
        c1_ff <= wdata_i;
      if (wr_i && is_reg(addr_i, `ASSC_IDX_CTRL2))
        c2_ff <= wdata_i;
      if (wr_i && is_reg(addr_i, `ASSC_IDX_BAUD))
        baud_ff <= wdata_i;
      if (!uen) begin
        c2_ff[`ASSC_C2_TRANSMITTER_ENABLE] <= 1'b0;
        c2_ff[`ASSC_C2_RECEIVER_ENABLE] <= 1'b0;
        c1_ff[`ASSC_C1_BRK]  <= 1'b0;
      end
    end
  end

  // Register reads; data stand only in the cycle after the strobe.
  always @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `ASSC_IDX_STATUS: rdata_o <= status;
        `ASSC_IDX_CTRL1:  rdata_o <= {c1_ff[7:2], rxq_ff[0][8], 1'b0};
        `ASSC_IDX_CTRL2:  rdata_o <= c2_ff;
        `ASSC_IDX_DATA:   rdata_o <= rxq_ff[0][7:0];
        `ASSC_IDX_BAUD:   rdata_o <= baud_ff;
        default:          rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Status read arms the clear sequence; a data access completes it.
  always @(posedge clock_i) begin
    if (rst_i || !uen)
      armed_ff <= 1'b0;
    else if (st_rd)
      armed_ff <= 1'b1;
    else if (rd_i || wr_i)
      armed_ff <= 1'b0;
  end

  // A released pin must not keep a stale low from an aborted frame.
  wire tx_low = tst_ff[1] | tst_ff[5] | (tst_ff[2] & ~t_sh_ff[0]) | (tst_ff[3] & ~t_par_ff);

  // Pins and interrupt request.
  always @(posedge clock_i) begin
    if (rst_i) begin
      tx_oe_n_o <= 1'b1;
      rx_en_o   <= 1'b0;
      irq_o     <= 1'b0;
      tx_o      <= 1'b1;
    end else begin
      tx_oe_n_o <= ~tx_on;
      rx_en_o   <= rx_on;
      irq_o     <= c2_ff[`ASSC_C2_RIE] & (overrun_flag_ff | receive_available_flag);
      tx_o      <= ~(tx_on & tx_low);
    end
  end

  // Transmitter.
  wire t_end = samp_ff & (t_ovs_ff == `ASSC_OVS_LAST);
  always @(posedge clock_i) begin
    if (rst_i || !tx_on) begin
      tst_ff    <= T_IDLE;
      t_ovs_ff  <= 4'h0;
      t_bit_ff  <= 4'h0;
      t_sh_ff   <= 9'h000;
      t_buf_ff  <= 9'h000;
      t_full_ff <= 1'b0;
      t_par_ff  <= 1'b0;
      transmit_empty_flag_ff   <= 1'b1;
      transmitter_enable_d_ff <= 1'b0;
    end else begin
      transmitter_enable_d_ff <= 1'b1;
      if (samp_ff)
        t_ovs_ff <= t_ovs_ff + 4'h1;
      if (dat_wr) begin
        t_buf_ff  <= {c1_ff[`ASSC_C1_TX8], wdata_i};
        t_full_ff <= 1'b1;
        if (armed_ff)
          transmit_empty_flag_ff <= 1'b0;
      end
      if (!transmitter_enable_d_ff)
        transmit_empty_flag_ff <= 1'b1;
      case (tst_ff)
        T_IDLE: begin
          t_ovs_ff <= 4'h0;
          t_bit_ff <= 4'h0;
          if (t_full_ff && !dat_wr) begin
            t_sh_ff   <= t_buf_ff;
            t_par_ff  <= ^(nine ? t_buf_ff : {1'b0, t_buf_ff[7:0]}) ^ podd;
            t_full_ff <= 1'b0;
            transmit_empty_flag_ff   <= 1'b1;
            tst_ff    <= T_START;
          end else if (brk && !t_full_ff) begin
            tst_ff <= T_BRK;
          end
        end
        T_START: if (t_end) tst_ff <= T_DATA;
        T_DATA: if (t_end) begin
          t_sh_ff  <= {1'b0, t_sh_ff[8:1]};
          t_bit_ff <= t_bit_ff + 4'h1;
          if (t_bit_ff == bits_last) begin
            t_bit_ff <= 4'h0;
            tst_ff   <= parity_enable ? T_PAR : T_STOP;
          end
        end
        T_PAR: if (t_end) tst_ff <= T_STOP;
        T_STOP: if (t_end) begin
          t_bit_ff <= t_bit_ff + 4'h1;
          if (!stop2 || t_bit_ff != 4'h0)
            tst_ff <= T_IDLE;
        end
        T_BRK: if (t_end) begin
          if (t_bit_ff != `ASSC_BRK_BITS)
            t_bit_ff <= t_bit_ff + 4'h1;
          else if (!brk) begin
            t_bit_ff <= 4'h0;
            tst_ff   <= T_STOP;
          end
        end
        default: tst_ff <= T_IDLE;
      endcase
    end
  end

  // Receive input synchroniser and filter.
  always @(posedge clock_i) begin
    if (rst_i) begin
      rx_sync_ff <= 3'h7;
      rx_filt_ff <= 1'b1;
    end else begin
      rx_sync_ff <= {rx_sync_ff[1:0], rx_i};
      if (rx_sync_ff[1] == rx_sync_ff[2])
        rx_filt_ff <= rx_sync_ff[2];
    end
  end

  // Receiver: three mid-bit samples, majority decides, disagreement is noise.
  wire       r_end  = samp_ff & (r_ovs_ff == `ASSC_OVS_LAST);
  wire       r_val  = maj3(r_smp_ff);
  wire       r_dis  = (r_smp_ff != 3'h0) & (r_smp_ff != 3'h7);
  wire       r_done = r_end & rst_ff[4];
  wire [8:0] r_word = nine ? r_sh_ff : {1'b0, r_sh_ff[8:1]};
  wire       r_parity_error_flag = parity_enable & (r_par_ff != (^r_word ^ podd));
  wire [11:0] r_ent = {r_parity_error_flag, r_nf_ff | r_dis, ~r_val, r_word};
  always @(posedge clock_i) begin
    if (rst_i || !rx_on) begin
      rst_ff   <= R_IDLE;
      r_ovs_ff <= 4'h0;
      r_bit_ff <= 4'h0;
      r_sh_ff  <= 9'h000;
      r_smp_ff <= 3'h7;
      r_nf_ff  <= 1'b0;
      r_par_ff <= 1'b0;
    end else begin
      if (samp_ff) begin
        r_ovs_ff <= r_ovs_ff + 4'h1;
        if (r_ovs_ff == `ASSC_SMP_A || r_ovs_ff == `ASSC_SMP_B || r_ovs_ff == `ASSC_SMP_C)
          r_smp_ff <= {r_smp_ff[1:0], rx_filt_ff};
      end
      case (rst_ff)
        R_IDLE: begin
          r_ovs_ff <= 4'h0;
          r_bit_ff <= 4'h0;
          r_nf_ff  <= 1'b0;
          if (!rx_filt_ff)
            rst_ff <= R_START;
        end
        R_START: if (r_end) begin
          r_nf_ff <= r_dis;
          rst_ff  <= r_val ? R_IDLE : R_DATA;
        end
        R_DATA: if (r_end) begin
          r_nf_ff  <= r_nf_ff | r_dis;
          r_sh_ff  <= {r_val, r_sh_ff[8:1]};
          r_bit_ff <= r_bit_ff + 4'h1;
          if (r_bit_ff == bits_last)
            rst_ff <= parity_enable ? R_PAR : R_STOP;
        end
        R_PAR: if (r_end) begin
          r_nf_ff  <= r_nf_ff | r_dis;
          r_par_ff <= r_val;
          rst_ff   <= R_STOP;
        end
        R_STOP: if (r_end) rst_ff <= R_IDLE;
        default: rst_ff <= R_IDLE;
      endcase
    end
  end

  // Two-word receive buffer and receive flags.
  wire       pop   = dat_rd & armed_ff & receive_available_flag;
  wire [1:0] left  = rx_cnt_ff - {1'b0, pop};
  wire       ovr   = r_done & (overrun_flag_ff | left[1]);
  wire       push  = r_done & ~ovr;
  wire       to_hd = push & (left == 2'h0);
  wire       up_hd = pop & rx_cnt_ff[1];
  always @(posedge clock_i) begin
    if (rst_i || !rx_on) begin
      rx_cnt_ff <= 2'h0;
      rxq_ff[0] <= 12'h000;
      rxq_ff[1] <= 12'h000;
      parity_error_flag_ff   <= 1'b0;
      nf_ff     <= 1'b0;
      framing_error_flag_ff   <= 1'b0;
      overrun_flag_ff   <= 1'b0;
    end else begin
      if (dat_acc) begin
        parity_error_flag_ff <= 1'b0;
        nf_ff   <= 1'b0;
        framing_error_flag_ff <= 1'b0;
        overrun_flag_ff <= 1'b0;
      end
      if (up_hd)
        rxq_ff[0] <= rxq_ff[1];
      if (push) begin
        if (left == 2'h0)
          rxq_ff[0] <= r_ent;
        else
          rxq_ff[1] <= r_ent;
      end
      rx_cnt_ff <= left + {1'b0, push};
      if (ovr)
        overrun_flag_ff <= 1'b1;
      if (to_hd || up_hd) begin
        parity_error_flag_ff <= parity_error_flag_ff & ~dat_acc | (to_hd ? r_ent[11] : rxq_ff[1][11]);
        nf_ff   <= nf_ff & ~dat_acc | (to_hd ? r_ent[10] : rxq_ff[1][10]);
        framing_error_flag_ff <= framing_error_flag_ff & ~dat_acc | (to_hd ? r_ent[9] : rxq_ff[1][9]);
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/assc_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module assc_checker (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rx_i,
  input wire logic       tx_o,
  input wire logic       tx_oe_n_o,
  input wire logic       rx_en_o,
  input wire logic       irq_o
);
  logic uen_ff;
  logic tx_on_ff;
  logic rx_on_ff;
  logic rie_ff;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // Shadow of the enables, so pin ownership is judged from bus traffic alone.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      uen_ff   <= 1'b0;
      tx_on_ff <= 1'b0;
      rx_on_ff <= 1'b0;
      rie_ff   <= 1'b0;
    end else if (wr_i && addr_i == 3'h1) begin
      uen_ff <= wdata_i[7];
      if (!wdata_i[7]) begin
        tx_on_ff <= 1'b0;
        rx_on_ff <= 1'b0;
      end
    end else if (wr_i && addr_i == 3'h2) begin
      tx_on_ff <= wdata_i[7] & uen_ff;
      rx_on_ff <= wdata_i[6] & uen_ff;
      rie_ff   <= wdata_i[2];
    end
  end
  chk_tx_float: assert property (!tx_on_ff |-> ##[1:2] tx_oe_n_o)
    else $error("tx pin driven while transmitter off");
  chk_rx_release: assert property (!rx_on_ff |-> ##[1:2] !rx_en_o)
    else $error("rx pin owned while receiver off");
  chk_idle_high: assert property (tx_oe_n_o |-> tx_o)
    else $error("tx line not high while released");
  chk_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  chk_unmapped_zero: assert property ($past(rd_i) && $past(addr_i) > 3'h4 |-> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_idle_status: assert property ($past(rd_i) && $past(addr_i) == 3'h0 && !$past(uen_ff)
    |-> rdata_o == 8'h0b)
    else $error("status wrong while port disabled");
  chk_enables_refused: assert property ($past(rd_i) && $past(addr_i) == 3'h2 && !$past(uen_ff)
    |-> rdata_o[7:6] == 2'h0)
    else $error("direction enables set while port disabled");
  chk_tx8_hidden: assert property ($past(rd_i) && $past(addr_i) == 3'h1 |-> !rdata_o[0])
    else $error("transmit ninth bit readable");
  chk_irq_masked: assert property (!rie_ff |=> !irq_o)
    else $error("interrupt raised while masked");
  cover property ($rose(irq_o));
  cover property ($fell(tx_o));
  cover property ($fell(rx_en_o));
endmodule
bind assc_top assc_checker u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .rx_i(rx_i), .tx_o(tx_o), .tx_oe_n_o(tx_oe_n_o), .rx_en_o(rx_en_o), .irq_o(irq_o)
);
`default_nettype wire

// File: verification/assc_peer.sv
`timescale 1ns/1ps
`default_nettype none
module assc_peer #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clock_i,
  input  wire logic tx_line_i,
  output var  logic rx_o
);
  initial rx_o = 1'b1;
  // The caller supplies every bit from start to stop; the last bit given stays on the line.
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rx_o <= bits[i];
      repeat (BIT_CLKS) @(posedge clock_i);
    end
  endtask
  // Samples on the falling edge, away from the launch edge of the device.
  task automatic recv(input int n, output logic [11:0] bits, output bit ok);
    int t;
    bits = 12'h000;
    t = 0;
    while (tx_line_i && t < 5000) begin
      @(negedge clock_i);
      t++;
    end
    ok = !tx_line_i;
    repeat (BIT_CLKS / 2) @(negedge clock_i);
    for (int i = 0; i < n; i++) begin
      bits[i] = tx_line_i;
      repeat (BIT_CLKS) @(negedge clock_i);
    end
  endtask
endmodule
`default_nettype wire

// File: verification/assc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module assc_top_tb;
  logic        clock_i;
  logic        rst_i;
  logic [2:0]  addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  wire  [7:0]  rdata_o;
  wire         rx_i;
  wire         tx_o;
  wire         tx_oe_n_o;
  wire         rx_en_o;
  wire         irq_o;
  wire         tx_line;
  int          num_errors;
  int          checks_done;
  int          n_low;
  logic [7:0]  d;
  logic [11:0] f;
  bit          ok;
  initial clock_i = 1'b0;
  always #10 clock_i = ~clock_i;
  // A released tx pin is pulled high.
  assign tx_line = tx_oe_n_o ? 1'b1 : tx_o;
  assc_top u_dut (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .rx_i(rx_i), .tx_o(tx_o), .tx_oe_n_o(tx_oe_n_o), .rx_en_o(rx_en_o), .irq_o(irq_o)
  );
  assc_peer u_peer (.clock_i(clock_i), .tx_line_i(tx_line), .rx_o(rx_i));
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    v = rdata_o;
    @(posedge clock_i);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    rd(a, d);
    chk({4'h0, d}, {4'h0, e});
  endtask
  task automatic wait_irq();
    int t;
    t = 0;
    while (irq_o !== 1'b1 && t < 3000) begin
      @(negedge clock_i);
      t++;
    end
    if (t >= 3000) begin
      num_errors++;
      finish_test();
    end
    @(posedge clock_i);
  endtask
  // Counts falling clock edges while the tx line stays at the given level.
  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (tx_line === lvl && n < 2000) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 2000) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic txcap(input int n, input logic [11:0] e);
    u_peer.recv(n, f, ok);
    if (!ok) begin
      num_errors++;
      finish_test();
    end
    chk(f, e);
    @(posedge clock_i);
  endtask
  initial begin
    rst_i   = 1'b1;
    addr_i  = 3'h0;
    wdata_i = 8'h00;
    wr_i    = 1'b0;
    rd_i    = 1'b0;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    rdc(3'h0, 8'h0b);
    rdc(3'h5, 8'h00);
    wr(3'h2, 8'hc0);
    rdc(3'h2, 8'h00);
    wr(3'h1, 8'h80);
    wr(3'h4, 8'h00);
    wr(3'h2, 8'he4);
    rdc(3'h0, 8'h0b);
    wr(3'h3, 8'ha5);
    txcap(10, {3'h1, 8'ha5, 1'b0});
    repeat (20) @(posedge clock_i);
    rdc(3'h0, 8'h0b);
    // Low speed: one tick every four clocks, so a data bit lasts 64 clocks.
    wr(3'h2, 8'hc4);
    wr(3'h3, 8'h01);
    run_len(1'b1, n_low);
    run_len(1'b0, n_low);
    run_len(1'b1, n_low);
    chk(n_low[11:0], 12'd64);
    repeat (600) @(posedge clock_i);
    wr(3'h2, 8'he4);
    u_peer.send({3'h1, 8'h3c, 1'b0}, 10);
    wait_irq();
    rdc(3'h0, 8'h0f);
    rdc(3'h3, 8'h3c);
    rdc(3'h0, 8'h0b);
    chk({11'h0, irq_o}, 12'h0);
    u_peer.send({2'h1, 1'b0, 8'h55, 1'b0}, 11);
    wait_irq();
    rdc(3'h0, 8'h2f);
    rdc(3'h3, 8'h55);
    rdc(3'h0, 8'h0b);
    // Each pass sends the parity bit i[0] with odd parity when i[1] is set.
    for (int i = 0; i < 4; i++) begin
      wr(3'h1, {3'h5, i[1], 4'h0});
      u_peer.send({2'h1, i[0], 8'h01, 1'b0}, 11);
      wait_irq();
      rdc(3'h0, {i[0] == i[1], 7'h0f});
      rdc(3'h3, 8'h01);
    end
    // Two stop bits: the queued second word starts only after both.
    wr(3'h1, 8'h88);
    rd(3'h0, d);
    wr(3'h3, 8'h00);
    wr(3'h3, 8'hff);
    txcap(12, {1'b0, 2'h3, 8'h00, 1'b0});
    repeat (200) @(posedge clock_i);
    wr(3'h1, 8'hc1);
    rd(3'h0, d);
    wr(3'h3, 8'h5a);
    txcap(11, {2'h3, 8'h5a, 1'b0});
    u_peer.send({2'h3, 8'h33, 1'b0}, 11);
    wait_irq();
    rdc(3'h1, 8'hc2);
    rdc(3'h0, 8'h0f);
    rdc(3'h3, 8'h33);
    wr(3'h1, 8'h80);
    for (int i = 1; i < 4; i++) begin
      u_peer.send({3'h1, 4'h0, i[3:0], 1'b0}, 10);
    end
    repeat (20) @(posedge clock_i);
    rdc(3'h0, 8'h1f);
    rdc(3'h3, 8'h01);
    wr(3'h1, 8'h84);
    repeat (10) @(posedge clock_i);
    n_low = 0;
    for (int i = 0; i < 240; i++) begin
      @(negedge clock_i);
      if (tx_line === 1'b0) n_low++;
    end
    chk(n_low[11:0], 12'd240);
    @(posedge clock_i);
    wr(3'h1, 8'h80);
    repeat (40) @(posedge clock_i);
    chk({11'h0, tx_line}, 12'h1);
    wr(3'h1, 8'h00);
    rdc(3'h2, 8'h24);
    rdc(3'h0, 8'h0b);
    chk({10'h0, tx_oe_n_o, rx_en_o}, 12'h2);
    finish_test();
  end
endmodule
`default_nettype wire
